// ===== src/adcec_top.sv
// Encode clock generation and sample capture for two converter channels
`timescale 1ns/100ps
`default_nettype none
module adcec_top
#(
	parameter int DIV_WIDTH = adcec_pkg::ADCEC_DIV_WIDTH
)
(
	input wire logic CLOCK,
	input wire logic RESET,
	input wire logic [DIV_WIDTH-1:0] HALF_PERIOD_A,
	input wire logic [DIV_WIDTH-1:0] HALF_PERIOD_B,
	input wire logic SINE_CLOCK_MODE,
	input wire logic SHARED_CLOCK_B,
	input wire logic SINE_CLOCK_IN,
	output logic ENCODE_A_OUT,
	output logic ENCODE_A_OE,
	output logic ENCODE_B_OUT,
	output logic ENCODE_B_OE,
	input wire adcec_pkg::adcec_sample_s ADC_A,
	input wire adcec_pkg::adcec_sample_s ADC_B,
	output adcec_pkg::adcec_sample_s SAMPLE_A,
	output adcec_pkg::adcec_sample_s SAMPLE_B,
	output logic SAMPLE_A_VALID,
	output logic SAMPLE_B_VALID,
	output logic LATENCY_READY_A,
	output logic LATENCY_READY_B
);
	import adcec_pkg::*;
	if (DIV_WIDTH < 1 || DIV_WIDTH > 16)
	begin : g_bad_width
		$error("adcec_top: DIV_WIDTH must be 1 to 16");
	end

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	logic [ADCEC_SYNC_BITS-1:0] pin_raw;
	logic [ADCEC_SYNC_BITS-1:0] sync1;
	logic [ADCEC_SYNC_BITS-1:0] sync2;
	logic [ADCEC_SYNC_BITS-1:0] sync3;
	logic [ADCEC_SYNC_BITS-1:0] pin_level;
	logic [ADCEC_SYNC_BITS-1:0] next_pin_level;
	assign pin_raw[ADCEC_SYNC_SINE_MODE] = SINE_CLOCK_MODE;
	assign pin_raw[ADCEC_SYNC_SHARED] = SHARED_CLOCK_B;
	assign pin_raw[ADCEC_SYNC_SINE_CLOCK] = SINE_CLOCK_IN;

	genvar gi;
	generate
		for (gi = 0; gi < ADCEC_SYNC_BITS; gi++)
		begin : g_sync
			// A change counts once the second and third stage agree
			always_comb
			begin
				next_pin_level[gi] = pin_level[gi];
				if (sync2[gi] == sync3[gi])
				begin
					next_pin_level[gi] = sync3[gi];
				end
			end

			always_ff @(posedge CLOCK or posedge RESET)
			begin
				if (RESET)
				begin
					sync1[gi] <= 1'b0;
					sync2[gi] <= 1'b0;
					sync3[gi] <= 1'b0;
					pin_level[gi] <= 1'b0;
				end
				else
				begin
					sync1[gi] <= pin_raw[gi];
					sync2[gi] <= sync1[gi];
					sync3[gi] <= sync2[gi];
					pin_level[gi] <= next_pin_level[gi];
				end
			end
		end
	endgenerate

	logic sine_mode;
	logic shared_b;
	logic sine_level;
	logic sine_prev;
	logic sine_rise;
	assign sine_mode = pin_level[ADCEC_SYNC_SINE_MODE];
	assign shared_b = pin_level[ADCEC_SYNC_SHARED];
	assign sine_level = pin_level[ADCEC_SYNC_SINE_CLOCK];

	always_ff @(posedge CLOCK or posedge RESET)
	begin
		if (RESET)
		begin
			sine_prev <= 1'b0;
		end
		else
		begin
			sine_prev <= sine_level;
		end
	end

	assign sine_rise = sine_level && !sine_prev;

	// ---------------------------------------------------------------
	// Encode clock sources
	// ---------------------------------------------------------------
	logic enc_a;
	logic enc_a_rise;
	logic enc_b;
	logic enc_b_rise;

	adcec_divider #(.WIDTH(DIV_WIDTH)) u_div_a
	(
		.clock(CLOCK),
		.reset(RESET),
		.half_period(HALF_PERIOD_A),
		.encode(enc_a),
		.encode_rise(enc_a_rise)
	);

	adcec_divider #(.WIDTH(DIV_WIDTH)) u_div_b
	(
		.clock(CLOCK),
		.reset(RESET),
		.half_period(HALF_PERIOD_B),
		.encode(enc_b),
		.encode_rise(enc_b_rise)
	);

	adcec_src_e src_a;
	adcec_src_e src_b;
	logic [1:0] event_ch;

	always_comb
	begin
		src_a = sine_mode ? ADCEC_SRC_SINE : ADCEC_SRC_DIVIDER;
		src_b = shared_b ? ADCEC_SRC_SHARED : ADCEC_SRC_DIVIDER;
		case (src_a)
			ADCEC_SRC_SINE: event_ch[0] = sine_rise;
			ADCEC_SRC_DIVIDER: event_ch[0] = enc_a_rise;
			default: event_ch[0] = enc_a_rise;
		endcase
		case (src_b)
			ADCEC_SRC_SHARED: event_ch[1] = event_ch[0];
			ADCEC_SRC_DIVIDER: event_ch[1] = enc_b_rise;
			default: event_ch[1] = enc_b_rise;
		endcase
	end

	// Separate outputs per channel; pins tied to the sine clock float
	assign ENCODE_A_OUT = enc_a;
	assign ENCODE_B_OUT = enc_b;
	assign ENCODE_A_OE = !sine_mode;
	assign ENCODE_B_OE = !(sine_mode && shared_b);

	// ---------------------------------------------------------------
	// Sample capture and latency tracking
	// ---------------------------------------------------------------
	adcec_sample_s adc_in [2];
	adcec_sample_s sample [2];
	logic [1:0] sample_valid;
	logic [3:0] fill [2];
	logic [1:0] src_changed;
	adcec_src_e src_prev [2];

	assign adc_in[0] = ADC_A;
	assign adc_in[1] = ADC_B;

	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_cap
			adcec_sample_s next_sample;
			logic next_valid;
			logic [3:0] next_fill;
			adcec_src_e src_now;

			assign src_now = (gi == 0) ? src_a : src_b;
			assign src_changed[gi] = (src_now != src_prev[gi]);

			// Word and over-range share one pad register stage
			always_comb
			begin
				next_sample = sample[gi];
				next_valid = event_ch[gi];
				next_fill = fill[gi];
				if (event_ch[gi])
				begin
					next_sample = adc_in[gi];
					if (fill[gi] != 4'(ADCEC_CAPTURE_LATENCY))
					begin
						next_fill = 4'(fill[gi] + 1'b1);
					end
				end
				if (src_changed[gi])
				begin
					next_fill = ADCEC_FILL_RESET;
				end
			end

			always_ff @(posedge CLOCK or posedge RESET)
			begin
				if (RESET)
				begin
					sample[gi] <= '0;
					sample_valid[gi] <= 1'b0;
					fill[gi] <= ADCEC_FILL_RESET;
					src_prev[gi] <= ADCEC_SRC_DIVIDER;
				end
				else
				begin
					sample[gi] <= next_sample;
					sample_valid[gi] <= next_valid;
					fill[gi] <= next_fill;
					src_prev[gi] <= src_now;
				end
			end
		end
	endgenerate

	assign SAMPLE_A = sample[0];
	assign SAMPLE_B = sample[1];
	assign SAMPLE_A_VALID = sample_valid[0];
	assign SAMPLE_B_VALID = sample_valid[1];
	assign LATENCY_READY_A = (fill[0] == 4'(ADCEC_CAPTURE_LATENCY));
	assign LATENCY_READY_B = (fill[1] == 4'(ADCEC_CAPTURE_LATENCY));

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	property p_sine_a_floats;
		@(posedge CLOCK) disable iff (RESET)
		sine_mode |-> !ENCODE_A_OE;
	endproperty
	a_sine_a_floats: assert property (p_sine_a_floats)
		else $error("encode A driven in sine clock mode");
	property p_sine_b_floats;
		@(posedge CLOCK) disable iff (RESET)
		(sine_mode && shared_b) |-> !ENCODE_B_OE;
	endproperty
	a_sine_b_floats: assert property (p_sine_b_floats)
		else $error("shared encode B driven in sine clock mode");
	property p_independent_b;
		@(posedge CLOCK) disable iff (RESET)
		!sine_mode |-> (ENCODE_A_OE && ENCODE_B_OE);
	endproperty
	a_independent_b: assert property (p_independent_b)
		else $error("encode output not driven in divider mode");
	property p_shared_follows_a;
		@(posedge CLOCK) disable iff (RESET)
		$past(shared_b) |-> (SAMPLE_B_VALID == SAMPLE_A_VALID);
	endproperty
	a_shared_follows_a: assert property (p_shared_follows_a)
		else $error("channel B not timed by encode A");
	property p_own_clock;
		@(posedge CLOCK) disable iff (RESET)
		(!shared_b && $rose(ENCODE_B_OUT)) |=> SAMPLE_B_VALID;
	endproperty
	a_own_clock: assert property (p_own_clock)
		else $error("capture not timed by own encode clock");
	property p_capture_a;
		@(posedge CLOCK) disable iff (RESET)
		event_ch[0] |=> (SAMPLE_A_VALID && SAMPLE_A == $past(ADC_A));
	endproperty
	a_capture_a: assert property (p_capture_a)
		else $error("channel A word not captured one stage on");
	property p_overrange_b;
		@(posedge CLOCK) disable iff (RESET)
		event_ch[1] |=> (SAMPLE_B.over_range == $past(ADC_B.over_range)
			&& SAMPLE_B.data == $past(ADC_B.data));
	endproperty
	a_overrange_b: assert property (p_overrange_b)
		else $error("channel B flag misaligned with its word");
	property p_ready_after_13;
		@(posedge CLOCK) disable iff (RESET)
		(event_ch[0] && !src_changed[0] && fill[0] == 4'h0c)
			|=> LATENCY_READY_A;
	endproperty
	a_ready_after_13: assert property (p_ready_after_13)
		else $error("channel A ready not set after 13 encodes");
endmodule
`default_nettype wire

// ===== include/adcec_pkg.sv
// Shared constants and types for the converter encode and capture block
package adcec_pkg;
	localparam int ADCEC_DATA_WIDTH = 12;
	localparam int ADCEC_CONV_LATENCY = 12;
	localparam int ADCEC_CAPTURE_LATENCY = ADCEC_CONV_LATENCY + 1;
	localparam int ADCEC_CLOCK_HZ = 40_000_000;
	localparam int ADCEC_SINE_MIN_HZ = 4_000_000;
	localparam int ADCEC_DIV_WIDTH = 8;
	localparam logic [7:0] ADCEC_HALF_PERIOD_RESET = 8'h01;
	localparam int ADCEC_SYNC_BITS = 3;
	localparam int ADCEC_SYNC_SINE_MODE = 0;
	localparam int ADCEC_SYNC_SHARED = 1;
	localparam int ADCEC_SYNC_SINE_CLOCK = 2;
	localparam logic [3:0] ADCEC_FILL_RESET = 4'h0;

	typedef struct packed
	{
		logic over_range;
		logic [ADCEC_DATA_WIDTH-1:0] data;
	} adcec_sample_s;

	typedef enum logic [1:0]
	{
		ADCEC_SRC_DIVIDER,
		ADCEC_SRC_SINE,
		ADCEC_SRC_SHARED
	} adcec_src_e;
endpackage

// ===== src/adcec_divider.sv
// Encode clock divider for one converter channel
`timescale 1ns/100ps
`default_nettype none
module adcec_divider
#(
	parameter int WIDTH = 8
)
(
	input wire logic clock,
	input wire logic reset,
	input wire logic [WIDTH-1:0] half_period,
	output logic encode,
	output logic encode_rise
);
	import adcec_pkg::*;

	logic [WIDTH-1:0] count;
	logic [WIDTH-1:0] next_count;
	logic next_encode;
	logic next_encode_rise;
	logic [WIDTH-1:0] last;

	if (WIDTH < 1)
	begin : g_bad_width
		$error("adcec_divider: WIDTH must be at least 1");
	end

	// A zero half period behaves as one
	always_comb
	begin
		last = (half_period == '0) ? '0 : WIDTH'(half_period - 1'b1);
		next_count = WIDTH'(count + 1'b1);
		next_encode = encode;
		next_encode_rise = 1'b0;
		if (count >= last)
		begin
			next_count = '0;
			next_encode = !encode;
			next_encode_rise = !encode;
		end
	end

	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			count <= '0;
			encode <= 1'b0;
			encode_rise <= 1'b0;
		end
		else
		begin
			count <= next_count;
			encode <= next_encode;
			encode_rise <= next_encode_rise;
		end
	end
endmodule
`default_nettype wire

// ===== verif/adcec_conv_model.sv
// Behavioural pipelined converter for one channel
`timescale 1ns/100ps
`default_nettype none
module adcec_conv_model
(
	input wire logic encode,
	input wire adcec_pkg::adcec_sample_s analog,
	output adcec_pkg::adcec_sample_s dout
);
	import adcec_pkg::*;
	adcec_sample_s pipe [ADCEC_CONV_LATENCY];
	initial
	begin
		dout = '0;
		foreach (pipe[i])
			pipe[i] = '0;
	end
	// Result shows just after the rise, twelve encodes late
	always @(posedge encode)
	begin
		dout <= #1 pipe[ADCEC_CONV_LATENCY-1];
		for (int i = ADCEC_CONV_LATENCY - 1; i > 0; i--)
			pipe[i] = pipe[i-1];
		pipe[0] = analog;
	end
endmodule
`default_nettype wire

// ===== verif/tb_top.sv
// Self-checking bench for the encode and capture block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import adcec_pkg::*;
	logic clock = 0;
	logic reset = 1;
	logic sine = 0;
	logic shared = 0;
	logic sine_in = 0;
	logic sine_run = 0;
	logic chk = 0;
	logic [1:0] fresh = 2'b11;
	logic [1:0] pe = 2'b00;
	logic [7:0] a, b;
	logic [7:0] hp [2] = '{8'h01, 8'h02};
	adcec_sample_s ana [2] = '{default: '0};
	adcec_sample_s hist [2][$];
	wire adcec_sample_s adc [2];
	wire adcec_sample_s smp [2];
	wire logic [1:0] enc, oe, val, rdy, ew;
	int per [2] = '{0, 0};
	int caps [2] = '{0, 0};
	int n_fail = 0;
	int tests_run = 0;
	int seed;

	// ----------------------------------------
	// Far side wiring and stimulus
	// ----------------------------------------
	// A released encode pin shows the inverse of what the block holds, except A in sine mode (sine clock) and B when shared (pin A)
	assign ew[0] = sine ? (oe[0] ? 1'bx : sine_in)
		: (oe[0] ? enc[0] : ~enc[0]);
	assign ew[1] = shared ? ew[0] : (oe[1] ? enc[1] : ~enc[1]);
	always #12.5 clock = ~clock;
	initial
	begin
		#3;
		forever #100 sine_in = sine_run & ~sine_in;
	end
	always @(negedge clock)
	begin
		ana[0] <= 13'($urandom);
		ana[1] <= 13'($urandom);
	end
	always @(posedge ew[0])
		hist[0].push_back(ana[0]);
	always @(posedge ew[1])
		hist[1].push_back(ana[1]);

	adcec_top DUT
	(
		.CLOCK(clock), .RESET(reset),
		.HALF_PERIOD_A(hp[0]), .HALF_PERIOD_B(hp[1]),
		.SINE_CLOCK_MODE(sine), .SHARED_CLOCK_B(shared),
		.SINE_CLOCK_IN(sine_in),
		.ENCODE_A_OUT(enc[0]), .ENCODE_A_OE(oe[0]),
		.ENCODE_B_OUT(enc[1]), .ENCODE_B_OE(oe[1]),
		.ADC_A(adc[0]), .ADC_B(adc[1]),
		.SAMPLE_A(smp[0]), .SAMPLE_B(smp[1]),
		.SAMPLE_A_VALID(val[0]), .SAMPLE_B_VALID(val[1]),
		.LATENCY_READY_A(rdy[0]), .LATENCY_READY_B(rdy[1])
	);
	adcec_conv_model conv_a (.encode(ew[0]), .analog(ana[0]), .dout(adc[0]));
	adcec_conv_model conv_b (.encode(ew[1]), .analog(ana[1]), .dout(adc[1]));

	// ----------------------------------------
	// Checking helpers
	// ----------------------------------------
	function automatic logic [15:0] exp_per(logic [7:0] h);
		return (h == 8'h00) ? 16'h0002 : {7'h00, h, 1'b0};
	endfunction
	function automatic logic exp_oe(int c);
		return (c == 0) ? !sine : !(sine && shared);
	endfunction
	task automatic check(string name, logic [15:0] exp, logic [15:0] got);
		tests_run++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic finish_test();
		$display("Checks %0d, mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic watch(int c);
		adcec_sample_s exp_s;
		if (enc[c] && !pe[c] && chk && exp_oe(c))
			check("period", exp_per(hp[c]), 16'(per[c]));
		per[c] = (enc[c] && !pe[c]) ? 1 : per[c] + 1;
		pe[c] = enc[c];
		if (chk)
			check("oe", 16'(exp_oe(c)), 16'(oe[c]));
		if (val[c] && fresh[c])
			check("ready", 16'(caps[c] >= 12), 16'(rdy[c]));
		if (val[c])
			caps[c]++;
		if (val[c] && chk && hist[c].size() > 12)
		begin
			exp_s = hist[c][hist[c].size()-13];
			check("sample", 16'(exp_s), 16'(smp[c]));
		end
	endtask
	always @(negedge clock)
	begin
		watch(0);
		watch(1);
		if (chk && shared && (val[0] || val[1]))
			check("shared", 16'(val[0]), 16'(val[1]));
	end
	task automatic wait_caps(int c, int n);
		repeat (600 * n)
		begin
			@(negedge clock);
			if (val[c] === 1'b1)
				n--;
			if (n == 0)
				return;
		end
		check("capture count", 16'h0000, 16'(n));
	endtask
	task automatic apply(logic [7:0] x, logic [7:0] y, logic s, logic j);
		@(negedge clock);
		chk <= 0;
		if (s != sine)
			fresh[0] <= 0;
		if (j != shared)
			fresh[1] <= 0;
		hp[0] <= x;
		hp[1] <= y;
		sine <= s;
		shared <= j;
		sine_run <= s;
		repeat (8) @(negedge clock);
		wait_caps(0, 3);
		wait_caps(1, 3);
		chk <= 1;
	endtask

	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial
	begin
		seed = $urandom(32'h9f34);
		repeat (3) @(posedge clock);
		@(negedge clock);
		reset <= 0;
		for (int r = 0; r < 6; r++)
		begin
			a = (r == 4) ? 8'h00 : 8'($urandom_range(1, 6));
			b = (r == 5) ? 8'hff : 8'($urandom_range(0, 6));
			apply(a, b, 0, 0);
			wait_caps(0, 20);
			wait_caps(1, 20);
			$display("Test divider round %0d done", r);
		end
		apply(8'h02, 8'h05, 0, 1);
		check("ready b cleared", 16'h0000, 16'(rdy[1]));
		wait_caps(1, 20);
		check("ready b refilled", 16'h0001, 16'(rdy[1]));
		$display("Test shared clock done");
		apply(8'h03, 8'h03, 1, 1);
		check("ready a cleared", 16'h0000, 16'(rdy[0]));
		wait_caps(0, 20);
		check("ready a refilled", 16'h0001, 16'(rdy[0]));
		$display("Test sine clock done");
		apply(8'h02, 8'h03, 1, 0);
		wait_caps(1, 20);
		$display("Test sine clock with own B clock done");
		apply(8'h01, 8'h01, 0, 0);
		wait_caps(0, 20);
		$display("Test return to divider done");
		finish_test();
	end
	initial
	begin
		#2_000_000;
		n_fail++;
		$display("[ERR] watchdog expected end seen timeout");
		finish_test();
	end
endmodule
`default_nettype wire
